// ===== design/boot_hdr_pkg.sv
// Constants, register map and types for the boot image header checker
package boot_hdr_pkg;

  // Image offsets of the header words
  localparam logic [11:0] OFF_HDR_START  = 12'h23A;
  localparam logic [11:0] OFF_COMMON     = 12'h242;
  localparam logic [11:0] OFF_SIGNATURE  = 12'h246;
  localparam logic [11:0] OFF_ENTRY      = 12'h24A;
  localparam logic [11:0] OFF_CLK_SYNTH  = 12'h24E;
  localparam logic [11:0] OFF_FLASH_A    = 12'h256;
  localparam logic [11:0] OFF_FLASH_B    = 12'h25A;
  localparam logic [11:0] OFF_FLASH_C    = 12'h25E;
  localparam logic [11:0] OFF_FLASH_OFFS = 12'h262;
  localparam logic [11:0] OFF_HDR_CHECK  = 12'h286;
  localparam logic [11:0] OFF_HDR_CHKEND = 12'h289;
  localparam logic [11:0] OFF_SEC_START  = 12'h28A;
  localparam logic [11:0] OFF_CODE_LEN   = 12'h28E;
  localparam logic [11:0] OFF_SRAM_ADDR  = 12'h296;
  localparam logic [11:0] OFF_BOOT_A     = 12'h29E;
  localparam logic [11:0] OFF_BOOT_B     = 12'h2A2;
  localparam logic [11:0] OFF_SEC_CHECK  = 12'h2B6;
  localparam logic [11:0] OFF_CODE_IMAGE = 12'h2BA;

  // Image layout figures
  localparam logic [3:0]  TAG_LAST_BYTE  = 4'hF;
  localparam int          OFFSET_EN_BIT  = 23;
  localparam logic [31:0] FLASH_BASE     = 32'h0000_0000;

  // CRC-16-CCITT
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY       = 16'h1021;

  // Reset and default values
  localparam logic [31:0] WORD_RESET     = 32'h0000_0000;
  localparam logic [31:0] FLASH_A_DEFAULT = 32'h0000_0000;
  localparam logic [31:0] FLASH_B_DEFAULT = 32'h0000_0000;
  localparam logic [31:0] FLASH_C_DEFAULT = 32'h0000_0000;
  localparam logic [31:0] FLASH_OFFS_DEFAULT = 32'h0000_0000;

  // Register byte addresses
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_STATUS      = 8'h04;
  localparam logic [7:0] REG_INT_STATUS  = 8'h08;
  localparam logic [7:0] REG_INT_CLEAR   = 8'h0C;
  localparam logic [7:0] REG_INT_ENABLE  = 8'h10;
  localparam logic [7:0] REG_ENTRY       = 8'h14;
  localparam logic [7:0] REG_CLK_SYNTH   = 8'h18;
  localparam logic [7:0] REG_FLASH_A     = 8'h1C;
  localparam logic [7:0] REG_FLASH_B     = 8'h20;
  localparam logic [7:0] REG_FLASH_C     = 8'h24;
  localparam logic [7:0] REG_FLASH_OFFS  = 8'h28;
  localparam logic [7:0] REG_CODE_LEN    = 8'h2C;
  localparam logic [7:0] REG_SRAM_ADDR   = 8'h30;
  localparam logic [7:0] REG_TAG0        = 8'h34;
  localparam logic [7:0] REG_TAG1        = 8'h38;
  localparam logic [7:0] REG_TAG2        = 8'h3C;
  localparam logic [7:0] REG_TAG3        = 8'h40;
  localparam logic [7:0] REG_COMMON      = 8'h44;
  localparam logic [7:0] REG_CODE_ADDR   = 8'h48;

  // Control register fields
  localparam int CTRL_START     = 0;
  localparam int CTRL_ENCRYPTED = 1;
  localparam int CTRL_SIGNED    = 2;
  localparam int CTRL_USB       = 3;
  localparam logic [2:0] OPTS_RESET = 3'h0;

  // Status register fields
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_LAUNCH  = 2;
  localparam int ST_SIG_OK  = 3;
  localparam int ST_HDR_OK  = 4;
  localparam int ST_SEC_OK  = 5;
  localparam int ST_ERROR   = 6;

  // Interrupt fields
  localparam int INT_DONE  = 0;
  localparam int INT_ERROR = 1;
  localparam logic [1:0] INT_RESET = 2'h0;

  typedef enum logic [1:0] {PH_IDLE, PH_HEADER, PH_TAG, PH_DONE} phase_t;

endpackage : boot_hdr_pkg

// ===== design/reg_access_if.sv
// Register access carrier between the bus port and the checker core
`timescale 1ns/1ps
interface reg_access_if;
  logic        wrEn;
  logic [7:0]  wrAddr;
  logic [31:0] wrData;
  logic [7:0]  rdAddr;
  logic [31:0] rdData;

  modport bus  (output wrEn, wrAddr, wrData, rdAddr, input rdData);
  modport core (input wrEn, wrAddr, wrData, rdAddr, output rdData);
endinterface : reg_access_if

// ===== design/crc16_ccitt.sv
// Byte-serial CRC-16-CCITT engine
`timescale 1ns/1ps
module crc16_ccitt
  import boot_hdr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clear,
  input  wire logic        enable,
  input  wire logic [7:0]  dataIn,
  output logic      [15:0] crcOut
);

  logic [15:0] crc_reg;
  logic [15:0] crc_next;

  function automatic logic [15:0] crcByte(input logic [15:0] c,
                                          input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crcByte

  always_comb begin
    crc_next = crc_reg;
    if (clear) begin
      crc_next = CRC_INIT;
    end else if (enable) begin
      crc_next = crcByte(crc_reg, dataIn);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_reg <= CRC_INIT;
    end else begin
      crc_reg <= crc_next;
    end
  end

  assign crcOut = crc_reg;

endmodule : crc16_ccitt

// ===== design/ahb_reg_port.sv
// AHB-Lite slave front end for the register file
`timescale 1ns/1ps
module ahb_reg_port (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  reg_access_if.bus        regs
);

  logic        accept;
  logic        wrPend_reg;
  logic        wrPend_next;
  logic [7:0]  wrAddr_reg;
  logic [7:0]  wrAddr_next;
  logic [31:0] rdData_reg;
  logic [31:0] rdData_next;

  // Address phase accepted for NONSEQ or SEQ
  assign accept = hsel & htrans[1] & hready;

  always_comb begin
    wrPend_next = accept & hwrite;
    wrAddr_next = accept ? haddr[7:0] : wrAddr_reg;
    rdData_next = (accept & ~hwrite) ? regs.rdData : rdData_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      rdData_reg <= 32'h0000_0000;
    end else begin
      wrPend_reg <= wrPend_next;
      wrAddr_reg <= wrAddr_next;
      rdData_reg <= rdData_next;
    end
  end

  // Write data phase holds one wait state while the write lands
  assign regs.wrEn   = wrPend_reg;
  assign regs.wrAddr = wrAddr_reg;
  assign regs.wrData = hwdata;
  assign regs.rdAddr = haddr[7:0];
  assign hreadyout   = ~wrPend_reg;
  assign hresp       = 1'b0;
  assign hrdata      = rdData_reg;

endmodule : ahb_reg_port

// ===== design/boot_image_header_checker.sv
// Boot image header parser and validator with AHB-Lite register file
//
// Overview of operation
// - The image is valid only if the word at 0x246 equals the signature.
// - The entry function address is taken from the word at 0x24A.
// - The clock synthesiser setting is taken from the word at 0x24E.
// - Flash words 0x256, 0x25A apply only if not encrypted, signed or USB.
// - Flash word 0x25E is ignored if encrypted or signed, not for USB.
// - With offset enable on and no option set, word 0x262 is added to the code image and tag addresses.
// - A CRC-16-CCITT over the boot header must equal check word 0x286.
// - The section header CRC must equal the low half of word 0x2B6.
// - Code length comes from 0x28E and the SRAM load address from 0x296.
// - The code image starts at image offset 0x2BA.
// - A 128-bit integrity tag follows the code image and is captured.
// - Every multi-byte field is little endian.
// - Bit 23 of the first flash word is the address offset enable.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module boot_image_header_checker
  import boot_hdr_pkg::*;
#(
  parameter logic [31:0] SIGNATURE_VALUE = 32'h5A3C_96E1  // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  output logic             flashReq,
  output logic      [31:0] flashAddr,
  input  wire logic        flashValid,
  input  wire logic [7:0]  flashData,
  output logic             launchEnable,
  output logic      [31:0] entryAddress,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg_access_if regIf ();

  phase_t       phase_reg,   phase_next;
  logic [11:0]  offs_reg,    offs_next;
  logic [23:0]  wbuf_reg,    wbuf_next;
  logic [3:0]   tagCnt_reg,  tagCnt_next;
  logic [127:0] tag_reg,     tag_next;
  logic [31:0]  common_reg,  common_next;
  logic [31:0]  entry_reg,   entry_next;
  logic [31:0]  synth_reg,   synth_next;
  logic [31:0]  rawA_reg,    rawA_next;
  logic [31:0]  rawB_reg,    rawB_next;
  logic [31:0]  rawC_reg,    rawC_next;
  logic [31:0]  rawOff_reg,  rawOff_next;
  logic [31:0]  code_length_reg, code_length_next;
  logic [31:0]  sram_reg,    sram_next;
  logic         sigOk_reg,   sigOk_next;
  logic         hdrOk_reg,   hdrOk_next;
  logic         secOk_reg,   secOk_next;
  logic         launch_reg,  launch_next;
  logic [2:0]   opts_reg,    opts_next;
  logic [1:0]   intSt_reg,   intSt_next;
  logic [1:0]   intEn_reg,   intEn_next;

  logic         byteTake, wordDone, inCheck, crcEn, crcClear, startReq;
  logic         cfgAB, cfgC;
  logic [11:0]  offsRel, fieldBase;
  logic [1:0]   events, intClr;
  logic [15:0]  crcVal;
  logic [31:0]  word, flashA, flashB, flashC, offsApplied, codeAddr;
  logic [31:0]  statusWord;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules
  ahb_reg_port u_bus (
    .clk       (clk),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .regs      (regIf.bus)
  );

  crc16_ccitt u_crc (
    .clk    (clk),
    .rst    (rst),
    .clear  (crcClear),
    .enable (crcEn),
    .dataIn (flashData),
    .crcOut (crcVal)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Applied configuration
  assign cfgAB  = ~(opts_reg[0] | opts_reg[1] | opts_reg[2]);
  assign cfgC   = ~(opts_reg[0] | opts_reg[1]);
  assign flashA = cfgAB ? rawA_reg : FLASH_A_DEFAULT;
  assign flashB = cfgAB ? rawB_reg : FLASH_B_DEFAULT;
  assign flashC = cfgC ? rawC_reg : FLASH_C_DEFAULT;
  assign offsApplied = (cfgAB && flashA[OFFSET_EN_BIT]) ?
                       rawOff_reg : FLASH_OFFS_DEFAULT;
  assign codeAddr = FLASH_BASE + offsApplied +
                    {20'h0_0000, OFF_CODE_IMAGE};

  ////////////////////////////////////////////////////////////////////////////
  // Byte stream and word assembly
  assign flashReq  = (phase_reg == PH_HEADER) || (phase_reg == PH_TAG);
  assign flashAddr = (phase_reg == PH_TAG) ?
                     (codeAddr + code_length_reg + {28'h000_0000, tagCnt_reg}) :
                     (FLASH_BASE + {20'h0_0000, offs_reg});
  assign byteTake  = flashReq & flashValid;
  assign offsRel   = offs_reg - OFF_HDR_START;
  assign wordDone  = byteTake && (phase_reg == PH_HEADER) &&
                     (offsRel[1:0] == 2'b11);
  assign fieldBase = offs_reg - 12'h003;
  assign word      = {flashData, wbuf_reg};
  assign inCheck   = ((offs_reg >= OFF_HDR_CHECK) &&
                      (offs_reg < OFF_SEC_START)) ||
                     (offs_reg >= OFF_SEC_CHECK);
  assign crcEn     = byteTake && (phase_reg == PH_HEADER) && !inCheck;
  assign crcClear  = startReq || (byteTake && (phase_reg == PH_HEADER) &&
                     (offs_reg == OFF_HDR_CHKEND));
  assign startReq  = regIf.wrEn && (regIf.wrAddr == REG_CTRL) &&
                     regIf.wrData[CTRL_START] &&
                     (phase_reg != PH_HEADER) && (phase_reg != PH_TAG);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    phase_next   = phase_reg;
    offs_next    = offs_reg;
    wbuf_next    = wbuf_reg;
    tagCnt_next  = tagCnt_reg;
    tag_next     = tag_reg;
    common_next  = common_reg;
    entry_next   = entry_reg;
    synth_next   = synth_reg;
    rawA_next    = rawA_reg;
    rawB_next    = rawB_reg;
    rawC_next    = rawC_reg;
    rawOff_next  = rawOff_reg;
    code_length_next = code_length_reg;
    sram_next    = sram_reg;
    sigOk_next   = sigOk_reg;
    hdrOk_next   = hdrOk_reg;
    secOk_next   = secOk_reg;
    launch_next  = launch_reg;
    events       = 2'b00;
    case (phase_reg)
      PH_IDLE, PH_DONE: begin
        if (startReq) begin
          phase_next   = PH_HEADER;
          offs_next    = OFF_HDR_START;
          tagCnt_next  = 4'h0;
          sigOk_next   = 1'b0;
          hdrOk_next   = 1'b0;
          secOk_next   = 1'b0;
          launch_next  = 1'b0;
          rawOff_next  = FLASH_OFFS_DEFAULT;
        end
      end
      PH_HEADER: begin
        if (byteTake) begin
          offs_next = offs_reg + 12'h001;
          wbuf_next = word[31:8];
        end
        if (wordDone) begin
          if (fieldBase == OFF_COMMON) common_next = word;
          else if (fieldBase == OFF_SIGNATURE)
            sigOk_next = (word == SIGNATURE_VALUE);
          else if (fieldBase == OFF_ENTRY) entry_next = word;
          else if (fieldBase == OFF_CLK_SYNTH) synth_next = word;
          else if (fieldBase == OFF_FLASH_A) rawA_next = word;
          else if (fieldBase == OFF_FLASH_B) rawB_next = word;
          else if (fieldBase == OFF_FLASH_C) rawC_next = word;
          else if (fieldBase == OFF_FLASH_OFFS) rawOff_next = word;
          else if (fieldBase == OFF_HDR_CHECK)
            hdrOk_next = (word[15:0] == crcVal);
          else if (fieldBase == OFF_CODE_LEN) code_length_next = word;
          else if (fieldBase == OFF_SRAM_ADDR) sram_next = word;
          else if (fieldBase == OFF_SEC_CHECK) begin
            secOk_next = (word[15:0] == crcVal);
            if (sigOk_reg && hdrOk_reg && (word[15:0] == crcVal)) begin
              phase_next = PH_TAG;
            end else begin
              phase_next = PH_DONE;
              events[INT_DONE]  = 1'b1;
              events[INT_ERROR] = 1'b1;
            end
          end
          // Reserved words only pass through the CRC
        end
      end
      PH_TAG: begin
        if (byteTake) begin
          tag_next    = {flashData, tag_reg[127:8]};
          tagCnt_next = tagCnt_reg + 4'h1;
          if (tagCnt_reg == TAG_LAST_BYTE) begin
            phase_next  = PH_DONE;
            launch_next = 1'b1;
            events[INT_DONE] = 1'b1;
          end
        end
      end
      default: begin
        phase_next = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg   <= PH_IDLE;
      offs_reg    <= OFF_HDR_START;
      wbuf_reg    <= 24'h00_0000;
      tagCnt_reg  <= 4'h0;
      tag_reg     <= {4{WORD_RESET}};
      common_reg  <= WORD_RESET;
      entry_reg   <= WORD_RESET;
      synth_reg   <= WORD_RESET;
      rawA_reg    <= FLASH_A_DEFAULT;
      rawB_reg    <= FLASH_B_DEFAULT;
      rawC_reg    <= FLASH_C_DEFAULT;
      rawOff_reg  <= FLASH_OFFS_DEFAULT;
      code_length_reg <= WORD_RESET;
      sram_reg    <= WORD_RESET;
      sigOk_reg   <= 1'b0;
      hdrOk_reg   <= 1'b0;
      secOk_reg   <= 1'b0;
      launch_reg  <= 1'b0;
    end else begin
      phase_reg   <= phase_next;
      offs_reg    <= offs_next;
      wbuf_reg    <= wbuf_next;
      tagCnt_reg  <= tagCnt_next;
      tag_reg     <= tag_next;
      common_reg  <= common_next;
      entry_reg   <= entry_next;
      synth_reg   <= synth_next;
      rawA_reg    <= rawA_next;
      rawB_reg    <= rawB_next;
      rawC_reg    <= rawC_next;
      rawOff_reg  <= rawOff_next;
      code_length_reg <= code_length_next;
      sram_reg    <= sram_next;
      sigOk_reg   <= sigOk_next;
      hdrOk_reg   <= hdrOk_next;
      secOk_reg   <= secOk_next;
      launch_reg  <= launch_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers and interrupt
  assign intClr = (regIf.wrEn && (regIf.wrAddr == REG_INT_CLEAR)) ?
                  regIf.wrData[1:0] : 2'b00;

  always_comb begin
    opts_next  = opts_reg;
    intEn_next = intEn_reg;
    if (regIf.wrEn && (regIf.wrAddr == REG_CTRL)) begin
      opts_next = regIf.wrData[CTRL_USB:CTRL_ENCRYPTED];
    end
    if (regIf.wrEn && (regIf.wrAddr == REG_INT_ENABLE)) begin
      intEn_next = regIf.wrData[1:0];
    end
    // A new event wins over a clear in the same cycle
    intSt_next = (intSt_reg & ~intClr) | events;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opts_reg  <= OPTS_RESET;
      intSt_reg <= INT_RESET;
      intEn_reg <= INT_RESET;
    end else begin
      opts_reg  <= opts_next;
      intSt_reg <= intSt_next;
      intEn_reg <= intEn_next;
    end
  end

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[ST_BUSY]   = flashReq;
    statusWord[ST_DONE]   = (phase_reg == PH_DONE);
    statusWord[ST_LAUNCH] = launch_reg;
    statusWord[ST_SIG_OK] = sigOk_reg;
    statusWord[ST_HDR_OK] = hdrOk_reg;
    statusWord[ST_SEC_OK] = secOk_reg;
    statusWord[ST_ERROR]  = (phase_reg == PH_DONE) && !launch_reg;
  end

  always_comb begin
    regIf.rdData = 32'h0000_0000;
    if (regIf.rdAddr == REG_CTRL) regIf.rdData = {28'h0, opts_reg, 1'b0};
    else if (regIf.rdAddr == REG_STATUS) regIf.rdData = statusWord;
    else if (regIf.rdAddr == REG_INT_STATUS) regIf.rdData = {30'h0, intSt_reg};
    else if (regIf.rdAddr == REG_INT_ENABLE) regIf.rdData = {30'h0, intEn_reg};
    else if (regIf.rdAddr == REG_ENTRY) regIf.rdData = entry_reg;
    else if (regIf.rdAddr == REG_CLK_SYNTH) regIf.rdData = synth_reg;
    else if (regIf.rdAddr == REG_FLASH_A) regIf.rdData = flashA;
    else if (regIf.rdAddr == REG_FLASH_B) regIf.rdData = flashB;
    else if (regIf.rdAddr == REG_FLASH_C) regIf.rdData = flashC;
    else if (regIf.rdAddr == REG_FLASH_OFFS) regIf.rdData = offsApplied;
    else if (regIf.rdAddr == REG_CODE_LEN) regIf.rdData = code_length_reg;
    else if (regIf.rdAddr == REG_SRAM_ADDR) regIf.rdData = sram_reg;
    else if (regIf.rdAddr == REG_TAG0) regIf.rdData = tag_reg[31:0];
    else if (regIf.rdAddr == REG_TAG1) regIf.rdData = tag_reg[63:32];
    else if (regIf.rdAddr == REG_TAG2) regIf.rdData = tag_reg[95:64];
    else if (regIf.rdAddr == REG_TAG3) regIf.rdData = tag_reg[127:96];
    else if (regIf.rdAddr == REG_COMMON) regIf.rdData = common_reg;
    else if (regIf.rdAddr == REG_CODE_ADDR) regIf.rdData = codeAddr;
  end

  assign irq          = |(intSt_reg & intEn_reg);
  assign launchEnable = launch_reg;
  assign entryAddress = entry_reg;

endmodule : boot_image_header_checker

// ===== test/boot_hdr_props.sv
// Checker of bus and flash fetch timing
`timescale 1ns/1ps
module boot_hdr_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        flashReq,
  input wire logic [31:0] flashAddr,
  input wire logic        flashValid,
  input wire logic        launchEnable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire take = hsel && htrans[1] && hready;
  bus_okay_a: assert property (hresp == 1'h0) else $error("bad hresp");
  wr_wait_a: assert property (take && hwrite |=> !hreadyout ##1 hreadyout)
    else $error("bad write wait");
  rd_fast_a: assert property (take && !hwrite |=> hreadyout)
    else $error("bad read wait");
  wait_cause_a: assert property ($fell(hreadyout) |-> $past(take && hwrite))
    else $error("stray wait");
  fetch_hold_a: assert property (flashReq && !flashValid |=>
    flashReq && $stable(flashAddr)) else $error("fetch dropped");
  hdr_order_a: assert property (
    flashReq && flashValid && flashAddr < 32'h0000_02B9 |=>
    flashAddr == $past(flashAddr) + 32'h0000_0001) else $error("bad order");
  fetch_base_a: assert property (
    flashReq |-> flashAddr >= 32'h0000_023A) else $error("bad address");
  launch_idle_a: assert property (
    flashReq |-> !launchEnable) else $error("launch while fetching");
endmodule : boot_hdr_props
bind boot_image_header_checker boot_hdr_props boot_hdr_props_i (.clk(clk),
  .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .flashReq(flashReq),
  .flashAddr(flashAddr), .flashValid(flashValid), .launchEnable(launchEnable));

// ===== test/flash_model.sv
// Flash byte source holding the boot image
`timescale 1ns/1ps
module flash_model (
  input  wire logic        clk,
  input  wire logic        flashReq,
  input  wire logic [31:0] flashAddr,
  output logic             flashValid,
  output logic      [7:0]  flashData
);
  logic [7:0] mem [0:2047];
  logic       go   = 1'h0;
  logic [7:0] junk = 8'h00;
  int         seed = 32'h0000_5A17;
  always @(posedge clk) begin
    go   <= ($random(seed) % 3) != 0;
    junk <= junk + 8'h5B;
  end
  // Byte at the asked address, junk outside a grant
  assign flashValid = flashReq && go;
  assign flashData  = flashValid ? mem[flashAddr[10:0]] : junk;
endmodule : flash_model

// ===== test/tb_top.sv
// Self-checking bench for the boot image header checker
`timescale 1ns/1ps
module tb_top;
  import boot_hdr_pkg::*;
  localparam logic [31:0] SIG = 32'h1E2D_3C4B; // Arbitrary value
  logic        clk, rst, hsel, hwrite, flashValid, flashReq, irq;
  logic        hreadyout, hresp, launchEnable;
  logic [1:0]  htrans;
  logic [7:0]  flashData;
  logic [31:0] haddr, hwdata, hrdata, flashAddr, entryAddress, rd;
  logic [31:0] w [10];
  logic [11:0] off [10] = '{OFF_COMMON, OFF_SIGNATURE, OFF_ENTRY,
    OFF_CLK_SYNTH, OFF_FLASH_A, OFF_FLASH_B, OFF_FLASH_C, OFF_FLASH_OFFS,
    OFF_CODE_LEN, OFF_SRAM_ADDR};
  int          mismatches = 0;
  int          cmp_count = 0;
  int          seed = 32'hdfe3;
  boot_image_header_checker #(.SIGNATURE_VALUE(SIG))
    boot_image_header_checker_i (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .flashReq(flashReq),
    .flashAddr(flashAddr), .flashValid(flashValid), .flashData(flashData),
    .launchEnable(launchEnable), .entryAddress(entryAddress), .irq(irq));
  flash_model flash_model_i (.clk(clk), .flashReq(flashReq),
    .flashAddr(flashAddr), .flashValid(flashValid), .flashData(flashData));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h00_0000, a};
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask : bus
  task automatic put(input int a, input logic [31:0] v);
    for (int b = 0; b < 4; b++) flash_model_i.mem[a + b] = v[8 * b +: 8];
  endtask : put
  function automatic logic [31:0] tw(input int a);
    return {flash_model_i.mem[a + 3], flash_model_i.mem[a + 2],
            flash_model_i.mem[a + 1], flash_model_i.mem[a]};
  endfunction : tw
  function automatic logic [15:0] crc(input int a, b);
    logic [15:0] c = CRC_INIT;
    for (int i = a; i <= b; i++) begin
      c ^= {flash_model_i.mem[i], 8'h00};
      for (int j = 0; j < 8; j++) c = c[15] ? (c << 1) ^ CRC_POLY : c << 1;
    end
    return c;
  endfunction : crc
  ////////////////////////////////////////////////////////////////////////////
  task automatic run(input int bad);
    logic [31:0] t, o;
    logic [31:0] ex [14];
    logic [7:0]  ra [14] = '{REG_ENTRY, REG_CLK_SYNTH, REG_FLASH_A,
      REG_FLASH_B, REG_FLASH_C, REG_FLASH_OFFS, REG_CODE_LEN, REG_SRAM_ADDR,
      REG_COMMON, REG_CODE_ADDR, REG_TAG0, REG_TAG1, REG_TAG2, REG_TAG3};
    for (int i = 0; i < 2048; i++) flash_model_i.mem[i] = $random(seed);
    for (int k = 0; k < 10; k++) w[k] = $random(seed);
    w[1] = (bad == 1) ? ~SIG : SIG;
    w[7] &= 32'h0000_00FF;
    w[8] &= 32'h0000_003F;
    for (int k = 0; k < 10; k++) put(off[k], w[k]);
    put(OFF_HDR_CHECK, crc(OFF_HDR_START, 'h285) ^ (bad == 2));
    put(OFF_SEC_CHECK, crc(OFF_SEC_START, 'h2B5) ^ (bad == 3));
    bus(1, REG_INT_ENABLE, 32'h0000_0003);
    bus(1, REG_CTRL, 32'h0000_0001);
    do bus(0, REG_STATUS, 0); while (rd[ST_DONE] !== 1'h1);
    chk("sig", rd[ST_SIG_OK], bad != 1);
    chk("hdr", rd[ST_HDR_OK], bad != 2);
    chk("sec", rd[ST_SEC_OK], bad != 3);
    chk("err", rd[ST_ERROR], bad != 0);
    chk("launch", launchEnable, bad == 0);
    chk("irq", irq, 1'h1);
    bus(0, REG_INT_STATUS, 0);
    chk("events", rd, {bad != 0, 1'h1});
    bus(1, REG_INT_CLEAR, 32'h0000_0003);
    chk("irq off", irq, 1'h0);
    o = w[4][OFFSET_EN_BIT] ? w[7] : 0;
    t = o + OFF_CODE_IMAGE + w[8];
    ex = '{w[2], w[3], w[4], w[5], w[6], o, w[8], w[9], w[0],
      o + OFF_CODE_IMAGE, tw(t), tw(t + 4), tw(t + 8), tw(t + 12)};
    for (int k = 0; k < 14 && bad == 0; k++) begin
      bus(0, ra[k], 0);
      chk("reg", rd, ex[k]);
    end
    chk("entry", entryAddress, w[2]);
    for (int m = 1; m < 8 && bad == 0; m++) begin
      bus(1, REG_CTRL, m << 1);
      bus(0, REG_FLASH_A, 0);
      chk("flash a", rd, 0);
      bus(0, REG_FLASH_C, 0);
      chk("flash c", rd, (m & 3) ? 0 : w[6]);
      bus(0, REG_FLASH_OFFS, 0);
      chk("offset", rd, 0);
    end
    bus(1, REG_CTRL, 0);
    bus(0, 8'hFC, 0);
    chk("unmapped", rd, 0);
    $display("Test %0d done", bad);
  endtask : run
  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    stop_test();
  end
  initial begin
    {rst, hsel, htrans, hwrite, haddr, hwdata} = {1'h1, 68'h0};
    repeat (12) @(posedge clk);
    chk("reset", {launchEnable, irq, flashReq}, 0);
    rst <= 1'h0;
    @(posedge clk);
    for (int b = 0; b < 5; b++) run(b % 4);
    stop_test();
  end
endmodule : tb_top
